/* File: pkg/ppfm_pkg.sv */
package ppfm_pkg;

  localparam int REMAP_PINS = 8;
  localparam int FIFTH_PINS = 6;
  localparam int MAP_W = 5;
  localparam int FUNC_NUM = 31;
  localparam int CHAN_W = 4;

  // Highest mapping value that selects a secondary function
  localparam logic [4:0] MAP_MAX = 5'h1E;
  localparam logic [3:0] CHAN_EIGHT = 4'h8;
  localparam logic [3:0] CHAN_NINE = 4'h9;

  // Byte offsets on the register bus
  localparam logic [7:0] OFS_REMAP_DIR = 8'h00;
  localparam logic [7:0] OFS_REMAP_SEL = 8'h04;
  localparam logic [7:0] OFS_REMAP_OUT = 8'h08;
  localparam logic [7:0] OFS_REMAP_IN = 8'h0C;
  localparam logic [7:0] OFS_FIFTH_DIR = 8'h10;
  localparam logic [7:0] OFS_FIFTH_SEL = 8'h14;
  localparam logic [7:0] OFS_FIFTH_OUT = 8'h18;
  localparam logic [7:0] OFS_FIFTH_IN = 8'h1C;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_MAP_BASE = 8'h40;

  // Control register fields
  localparam int CTL_REFERENCE_OUTPUT_ENABLE = 0;
  localparam int CTL_HF_BYP = 1;
  localparam int CTL_LF_BYP = 2;
  localparam int CTL_CHAN_LSB = 4;

  // Fifth-port pin roles
  localparam int PIN_POS_REF = 0;
  localparam int PIN_NEG_REF = 1;
  localparam int PIN_HF_IN = 2;
  localparam int PIN_HF_OUT = 3;
  localparam int PIN_LF_IN = 4;
  localparam int PIN_LF_OUT = 5;

  typedef struct packed {
    logic [REMAP_PINS-1:0] out;
    logic [REMAP_PINS-1:0] oe;
    logic [REMAP_PINS-1:0] in_en;
  } ppfm_remap_pad_t;

  typedef struct packed {
    logic [FIFTH_PINS-1:0] out;
    logic [FIFTH_PINS-1:0] oe;
    logic [FIFTH_PINS-1:0] in_en;
  } ppfm_fifth_pad_t;

  typedef struct packed {
    logic converter_channel_eight;
    logic converter_channel_nine;
    logic external_positive_reference;
    logic internal_positive_drive;
    logic external_negative_reference;
    logic internal_negative_drive;
  } ppfm_analog_t;

  typedef struct packed {
    logic hf_oscillator_input;
    logic hf_bypass_mode;
    logic hf_oscillator_output;
    logic hf_bypass_clock;
    logic lf_oscillator_input;
    logic lf_bypass_mode;
    logic lf_oscillator_output;
    logic lf_bypass_clock;
  } ppfm_osc_t;

endpackage

/* File: hw/ppfm_port_mux.sv */
module ppfm_port_mux #(
  parameter logic [30:0] MODULE_DIR_MASK = 31'h00000000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [ppfm_pkg::REMAP_PINS-1:0] remap_pin_in,
  output ppfm_pkg::ppfm_remap_pad_t remap_pad,
  input wire logic [ppfm_pkg::FUNC_NUM-1:0] periph_out,
  input wire logic [ppfm_pkg::FUNC_NUM-1:0] periph_oe,
  output logic [ppfm_pkg::FUNC_NUM-1:0] periph_in,
  input wire logic [ppfm_pkg::FIFTH_PINS-1:0] fifth_pin_in,
  output ppfm_pkg::ppfm_fifth_pad_t fifth_pad,
  output ppfm_pkg::ppfm_analog_t analog,
  output ppfm_pkg::ppfm_osc_t osc
);

  typedef struct packed {
    logic dp_write;
    logic [7:0] dp_addr;
    logic [ppfm_pkg::REMAP_PINS-1:0] remap_port_direction;
    logic [ppfm_pkg::REMAP_PINS-1:0] remap_port_function_select;
    logic [ppfm_pkg::REMAP_PINS-1:0] remap_port_output;
    logic [ppfm_pkg::REMAP_PINS-1:0][ppfm_pkg::MAP_W-1:0] pin_mapping_value;
    logic [ppfm_pkg::FIFTH_PINS-1:0] fifth_port_direction;
    logic [ppfm_pkg::FIFTH_PINS-1:0] fifth_port_function_select;
    logic [ppfm_pkg::FIFTH_PINS-1:0] fifth_port_output;
    logic reference_output_enable;
    logic hf_oscillator_bypass;
    logic lf_oscillator_bypass;
    logic [ppfm_pkg::CHAN_W-1:0] converter_channel_select;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    ppfm_pkg::ppfm_remap_pad_t remap_pad;
    ppfm_pkg::ppfm_fifth_pad_t fifth_pad;
    ppfm_pkg::ppfm_analog_t analog;
    ppfm_pkg::ppfm_osc_t osc;
    logic [ppfm_pkg::FUNC_NUM-1:0] periph_in;
  } ppfm_state_t;

  ppfm_state_t s;
  ppfm_state_t next_s;

  // Mapping registers occupy one word each in the 0x40..0x5C window
  function automatic logic map_hit(input logic [7:0] a);
    return (a[7:5] == ppfm_pkg::OFS_MAP_BASE[7:5]) && (a[1:0] == 2'b00);
  endfunction

  always_comb begin
    logic [ppfm_pkg::MAP_W-1:0] mv;
    logic hf_xtal;
    logic lf_xtal;
    mv = '0;
    hf_xtal = 1'b0;
    lf_xtal = 1'b0;
    next_s = s;
    next_s.hreadyout = 1'b1;
    next_s.hresp = 1'b0;

    // Data phase of a write: hwdata is valid now
    if (s.dp_write) begin
      case (s.dp_addr)
        ppfm_pkg::OFS_REMAP_DIR: begin
          next_s.remap_port_direction = hwdata[ppfm_pkg::REMAP_PINS-1:0];
        end
        ppfm_pkg::OFS_REMAP_SEL: begin
          next_s.remap_port_function_select = hwdata[ppfm_pkg::REMAP_PINS-1:0];
        end
        ppfm_pkg::OFS_REMAP_OUT: begin
          next_s.remap_port_output = hwdata[ppfm_pkg::REMAP_PINS-1:0];
        end
        ppfm_pkg::OFS_FIFTH_DIR: begin
          next_s.fifth_port_direction = hwdata[ppfm_pkg::FIFTH_PINS-1:0];
        end
        ppfm_pkg::OFS_FIFTH_SEL: begin
          next_s.fifth_port_function_select = hwdata[ppfm_pkg::FIFTH_PINS-1:0];
        end
        ppfm_pkg::OFS_FIFTH_OUT: begin
          next_s.fifth_port_output = hwdata[ppfm_pkg::FIFTH_PINS-1:0];
        end
        ppfm_pkg::OFS_CTRL: begin
          next_s.reference_output_enable = hwdata[ppfm_pkg::CTL_REFERENCE_OUTPUT_ENABLE];
          next_s.hf_oscillator_bypass = hwdata[ppfm_pkg::CTL_HF_BYP];
          next_s.lf_oscillator_bypass = hwdata[ppfm_pkg::CTL_LF_BYP];
          next_s.converter_channel_select = hwdata[ppfm_pkg::CTL_CHAN_LSB +: ppfm_pkg::CHAN_W];
        end
        default: begin
          if (map_hit(s.dp_addr)) begin
            next_s.pin_mapping_value[s.dp_addr[4:2]] = hwdata[ppfm_pkg::MAP_W-1:0];
          end
        end
      endcase
    end

    // Remappable port
    next_s.periph_in = '0;
    for (int i = 0; i < ppfm_pkg::REMAP_PINS; i++) begin
      mv = next_s.pin_mapping_value[i];
      if (!next_s.remap_port_function_select[i]) begin
        next_s.remap_pad.out[i] = next_s.remap_port_output[i];
        next_s.remap_pad.oe[i] = next_s.remap_port_direction[i];
        next_s.remap_pad.in_en[i] = 1'b1;
      end else if (mv <= ppfm_pkg::MAP_MAX) begin
        next_s.remap_pad.out[i] = periph_out[mv];
        next_s.remap_pad.in_en[i] = 1'b1;
        next_s.periph_in[mv] = next_s.periph_in[mv] | remap_pin_in[i];
        if (MODULE_DIR_MASK[mv]) begin
          next_s.remap_pad.oe[i] = periph_oe[mv];
        end else begin
          next_s.remap_pad.oe[i] = next_s.remap_port_direction[i];
        end
      end else begin
        // Out-of-range mapping parks the pin rather than guess a function
        next_s.remap_pad.out[i] = 1'b0;
        next_s.remap_pad.oe[i] = 1'b0;
        next_s.remap_pad.in_en[i] = 1'b0;
      end
    end

    // Fifth port: plain I/O first, then each special function overrides
    next_s.fifth_pad.out = next_s.fifth_port_output;
    next_s.fifth_pad.oe = next_s.fifth_port_direction;
    next_s.fifth_pad.in_en = '1;

    // Analog pins: driver and Schmitt input off to avoid cross currents
    next_s.analog = '0;
    if (next_s.fifth_port_function_select[ppfm_pkg::PIN_POS_REF]) begin
      next_s.fifth_pad.out[ppfm_pkg::PIN_POS_REF] = 1'b0;
      next_s.fifth_pad.oe[ppfm_pkg::PIN_POS_REF] = 1'b0;
      next_s.fifth_pad.in_en[ppfm_pkg::PIN_POS_REF] = 1'b0;
      next_s.analog.converter_channel_eight =
        (next_s.converter_channel_select == ppfm_pkg::CHAN_EIGHT);
      next_s.analog.external_positive_reference = !next_s.reference_output_enable;
      next_s.analog.internal_positive_drive = next_s.reference_output_enable;
    end
    if (next_s.fifth_port_function_select[ppfm_pkg::PIN_NEG_REF]) begin
      next_s.fifth_pad.out[ppfm_pkg::PIN_NEG_REF] = 1'b0;
      next_s.fifth_pad.oe[ppfm_pkg::PIN_NEG_REF] = 1'b0;
      next_s.fifth_pad.in_en[ppfm_pkg::PIN_NEG_REF] = 1'b0;
      next_s.analog.converter_channel_nine =
        (next_s.converter_channel_select == ppfm_pkg::CHAN_NINE);
      next_s.analog.external_negative_reference = !next_s.reference_output_enable;
      next_s.analog.internal_negative_drive = next_s.reference_output_enable;
    end

    // Oscillator pins; the output pin's own select bit is never consulted
    next_s.osc = '0;
    if (next_s.fifth_port_function_select[ppfm_pkg::PIN_HF_IN]) begin
      hf_xtal = !next_s.hf_oscillator_bypass;
      next_s.fifth_pad.out[ppfm_pkg::PIN_HF_IN] = 1'b0;
      next_s.fifth_pad.oe[ppfm_pkg::PIN_HF_IN] = 1'b0;
      // Bypass needs the digital input buffer to pass the external clock
      next_s.fifth_pad.in_en[ppfm_pkg::PIN_HF_IN] = next_s.hf_oscillator_bypass;
      next_s.osc.hf_oscillator_input = 1'b1;
      next_s.osc.hf_bypass_mode = next_s.hf_oscillator_bypass;
      next_s.osc.hf_bypass_clock = next_s.hf_oscillator_bypass & fifth_pin_in[ppfm_pkg::PIN_HF_IN];
    end
    if (hf_xtal) begin
      next_s.fifth_pad.out[ppfm_pkg::PIN_HF_OUT] = 1'b0;
      next_s.fifth_pad.oe[ppfm_pkg::PIN_HF_OUT] = 1'b0;
      next_s.fifth_pad.in_en[ppfm_pkg::PIN_HF_OUT] = 1'b0;
      next_s.osc.hf_oscillator_output = 1'b1;
    end
    if (next_s.fifth_port_function_select[ppfm_pkg::PIN_LF_IN]) begin
      lf_xtal = !next_s.lf_oscillator_bypass;
      next_s.fifth_pad.out[ppfm_pkg::PIN_LF_IN] = 1'b0;
      next_s.fifth_pad.oe[ppfm_pkg::PIN_LF_IN] = 1'b0;
      next_s.fifth_pad.in_en[ppfm_pkg::PIN_LF_IN] = next_s.lf_oscillator_bypass;
      next_s.osc.lf_oscillator_input = 1'b1;
      next_s.osc.lf_bypass_mode = next_s.lf_oscillator_bypass;
      next_s.osc.lf_bypass_clock = next_s.lf_oscillator_bypass & fifth_pin_in[ppfm_pkg::PIN_LF_IN];
    end
    if (lf_xtal) begin
      next_s.fifth_pad.out[ppfm_pkg::PIN_LF_OUT] = 1'b0;
      next_s.fifth_pad.oe[ppfm_pkg::PIN_LF_OUT] = 1'b0;
      next_s.fifth_pad.in_en[ppfm_pkg::PIN_LF_OUT] = 1'b0;
      next_s.osc.lf_oscillator_output = 1'b1;
    end

    // Address phase; reads use next values so a read right after a write sees it
    next_s.dp_write = hsel & hready & htrans[1] & hwrite;
    next_s.dp_addr = haddr[7:0];
    if (hsel & hready & htrans[1] & !hwrite) begin
      next_s.hrdata = '0;
      case (haddr[7:0])
        ppfm_pkg::OFS_REMAP_DIR: begin
          next_s.hrdata[ppfm_pkg::REMAP_PINS-1:0] = next_s.remap_port_direction;
        end
        ppfm_pkg::OFS_REMAP_SEL: begin
          next_s.hrdata[ppfm_pkg::REMAP_PINS-1:0] = next_s.remap_port_function_select;
        end
        ppfm_pkg::OFS_REMAP_OUT: begin
          next_s.hrdata[ppfm_pkg::REMAP_PINS-1:0] = next_s.remap_port_output;
        end
        ppfm_pkg::OFS_REMAP_IN: begin
          next_s.hrdata[ppfm_pkg::REMAP_PINS-1:0] = remap_pin_in & next_s.remap_pad.in_en;
        end
        ppfm_pkg::OFS_FIFTH_DIR: begin
          next_s.hrdata[ppfm_pkg::FIFTH_PINS-1:0] = next_s.fifth_port_direction;
        end
        ppfm_pkg::OFS_FIFTH_SEL: begin
          next_s.hrdata[ppfm_pkg::FIFTH_PINS-1:0] = next_s.fifth_port_function_select;
        end
        ppfm_pkg::OFS_FIFTH_OUT: begin
          next_s.hrdata[ppfm_pkg::FIFTH_PINS-1:0] = next_s.fifth_port_output;
        end
        ppfm_pkg::OFS_FIFTH_IN: begin
          next_s.hrdata[ppfm_pkg::FIFTH_PINS-1:0] = fifth_pin_in & next_s.fifth_pad.in_en;
        end
        ppfm_pkg::OFS_CTRL: begin
          next_s.hrdata[ppfm_pkg::CTL_REFERENCE_OUTPUT_ENABLE] = next_s.reference_output_enable;
          next_s.hrdata[ppfm_pkg::CTL_HF_BYP] = next_s.hf_oscillator_bypass;
          next_s.hrdata[ppfm_pkg::CTL_LF_BYP] = next_s.lf_oscillator_bypass;
          next_s.hrdata[ppfm_pkg::CTL_CHAN_LSB +: ppfm_pkg::CHAN_W] = next_s.converter_channel_select;
        end
        ppfm_pkg::OFS_STATUS: begin
          next_s.hrdata[7:0] = next_s.osc;
          next_s.hrdata[13:8] = next_s.analog;
        end
        default: begin
          if (map_hit(haddr[7:0])) begin
            next_s.hrdata[ppfm_pkg::MAP_W-1:0] = next_s.pin_mapping_value[haddr[4:2]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign remap_pad = s.remap_pad;
  assign periph_in = s.periph_in;
  assign fifth_pad = s.fifth_pad;
  assign analog = s.analog;
  assign osc = s.osc;

endmodule

/* File: testbench/ppfm_assertions.sv */
module ppfm_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [ppfm_pkg::FIFTH_PINS-1:0] fifth_pin_in,
  input wire ppfm_pkg::ppfm_remap_pad_t remap_pad,
  input wire ppfm_pkg::ppfm_fifth_pad_t fifth_pad,
  input wire ppfm_pkg::ppfm_analog_t analog,
  input wire ppfm_pkg::ppfm_osc_t osc
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pos_ref_pad: assert property (analog.external_positive_reference || analog.internal_positive_drive |->
    fifth_pad.oe[0] == 1'b0 && fifth_pad.in_en[0] == 1'b0) else $error("pin 0 pad active in analog use");
  a_pos_ref_excl: assert property (!(analog.external_positive_reference && analog.internal_positive_drive))
    else $error("both positive reference paths on");
  a_chan_eight_sel: assert property (analog.converter_channel_eight |->
    analog.external_positive_reference || analog.internal_positive_drive) else $error("channel 8 without pin 0");
  a_neg_ref_pad: assert property (analog.external_negative_reference || analog.internal_negative_drive |->
    fifth_pad.oe[1] == 1'b0 && fifth_pad.in_en[1] == 1'b0) else $error("pin 1 pad active in analog use");
  a_neg_ref_excl: assert property (!(analog.external_negative_reference && analog.internal_negative_drive))
    else $error("both negative reference paths on");
  a_hf_in_pad: assert property (osc.hf_oscillator_input |->
    fifth_pad.oe[2] == 1'b0 && fifth_pad.in_en[2] == osc.hf_bypass_mode) else $error("pin 2 pad wrong");
  a_hf_out_mode: assert property (osc.hf_oscillator_output |-> osc.hf_oscillator_input && !osc.hf_bypass_mode
    && fifth_pad.oe[3] == 1'b0 && fifth_pad.in_en[3] == 1'b0) else $error("pin 3 output wrong");
  a_lf_in_pad: assert property (osc.lf_oscillator_input |->
    fifth_pad.oe[4] == 1'b0 && fifth_pad.in_en[4] == osc.lf_bypass_mode) else $error("pin 4 pad wrong");
  a_lf_out_mode: assert property (osc.lf_oscillator_output |-> osc.lf_oscillator_input && !osc.lf_bypass_mode
    && fifth_pad.oe[5] == 1'b0 && fifth_pad.in_en[5] == 1'b0) else $error("pin 5 output wrong");
  a_hf_clk_follow: assert property (osc.hf_bypass_mode && $past(osc.hf_bypass_mode) |->
    osc.hf_bypass_clock == $past(fifth_pin_in[ppfm_pkg::PIN_HF_IN])) else $error("bypass clock lags");
  a_lf_clk_follow: assert property (osc.lf_bypass_mode && $past(osc.lf_bypass_mode) |->
    osc.lf_bypass_clock == $past(fifth_pin_in[ppfm_pkg::PIN_LF_IN])) else $error("low bypass clock lags");
  a_park_quiet: assert property (((remap_pad.out | remap_pad.oe) & ~remap_pad.in_en) == 8'h00)
    else $error("parked pin still active");
  a_reset_gpio: assert property ($rose(hresetn) |=> fifth_pad.in_en == 6'h3F && fifth_pad.oe == 6'h00
    && remap_pad.oe == 8'h00) else $error("pads not plain inputs after reset");
  a_ready_high: assert property (hreadyout == 1'b1) else $error("register bus stalled");
  a_resp_okay: assert property (hresp == 1'b0) else $error("register bus error response");
endmodule

bind ppfm_port_mux ppfm_assertions ppfm_assertions_inst (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .fifth_pin_in(fifth_pin_in), .remap_pad(remap_pad), .fifth_pad(fifth_pad), .analog(analog),
  .osc(osc));

/* File: testbench/ppfm_pin_model.sv */
module ppfm_pin_model (
  input wire ppfm_pkg::ppfm_remap_pad_t remap_pad,
  input wire ppfm_pkg::ppfm_fifth_pad_t fifth_pad,
  input wire logic [7:0] remap_ext,
  input wire logic [5:0] fifth_ext,
  output logic [7:0] remap_pin_in,
  output logic [5:0] fifth_pin_in
);
  // Pins not driven by the pad show the board level, so loopback reads prove who drives
  assign remap_pin_in = (remap_pad.oe & remap_pad.out) | (~remap_pad.oe & remap_ext);
  assign fifth_pin_in = (fifth_pad.oe & fifth_pad.out) | (~fifth_pad.oe & fifth_ext);
endmodule

/* File: testbench/ppfm_port_mux_tb_top.sv */
module ppfm_port_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic [7:0] remap_pin_in;
  logic [7:0] remap_ext = 8'h0F;
  logic [5:0] fifth_pin_in;
  logic [5:0] fifth_ext = 6'h15;
  logic [30:0] periph_out = 31'h55555555;
  logic [30:0] periph_oe = 31'h0;
  logic [30:0] periph_in;
  ppfm_pkg::ppfm_remap_pad_t remap_pad;
  ppfm_pkg::ppfm_fifth_pad_t fifth_pad;
  ppfm_pkg::ppfm_analog_t analog;
  ppfm_pkg::ppfm_osc_t osc;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  ppfm_port_mux #(.MODULE_DIR_MASK(31'h00000010)) ppfm_port_mux_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .remap_pin_in(remap_pin_in), .remap_pad(remap_pad),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in), .fifth_pin_in(fifth_pin_in),
    .fifth_pad(fifth_pad), .analog(analog), .osc(osc));
  ppfm_pin_model ppfm_pin_model_inst (.remap_pad(remap_pad), .fifth_pad(fifth_pad), .remap_ext(remap_ext),
    .fifth_ext(fifth_ext), .remap_pin_in(remap_pin_in), .fifth_pin_in(fifth_pin_in));

  initial forever #10 hclk = ~hclk;

  task automatic test_done;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Master waits on hready at every phase; no wait-state count is assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic t_reset;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    check("fifth in_en", fifth_pad.in_en, 6'h3F);
    check("fifth oe", fifth_pad.oe, 6'h00);
    check("remap oe", remap_pad.oe, 8'h00);
    check("analog", analog, 6'h00);
    check("osc", osc, 8'h00);
  endtask

  task automatic t_gpio;
    wr(ppfm_pkg::OFS_MAP_BASE, 32'h5);
    wr(ppfm_pkg::OFS_REMAP_DIR, 32'hA5);
    wr(ppfm_pkg::OFS_REMAP_OUT, 32'h3C);
    wr(ppfm_pkg::OFS_FIFTH_DIR, 32'h2A);
    wr(ppfm_pkg::OFS_FIFTH_OUT, 32'h3F);
    repeat (3) @(posedge hclk);
    check("remap oe", remap_pad.oe, 8'hA5);
    check("remap out", remap_pad.out & 8'hA5, 8'h24);
    check("fifth oe", fifth_pad.oe, 6'h2A);
    rdchk("remap in", ppfm_pkg::OFS_REMAP_IN, 8'h24 | (remap_ext & 8'h5A));
    rdchk("fifth in", ppfm_pkg::OFS_FIFTH_IN, 6'h2A | (fifth_ext & 6'h15));
    rdchk("unmapped", 8'h30, 32'h0);
  endtask

  task automatic t_mapped;
    periph_oe <= 31'h7FFFFFFF;
    for (int i = 0; i < 8; i++) begin
      wr(ppfm_pkg::OFS_MAP_BASE + 8'(4 * i), (i == 7) ? 32'd30 : 32'(4 * i));
    end
    wr(ppfm_pkg::OFS_REMAP_DIR, 32'h0);
    wr(ppfm_pkg::OFS_REMAP_SEL, 32'hFF);
    repeat (3) @(posedge hclk);
    check("module oe", remap_pad.oe, 8'h02);
    check("mapped out", remap_pad.out & 8'h02, 8'h02);
    check("periph in", periph_in, 31'h00001111);
    rdchk("sel", ppfm_pkg::OFS_REMAP_SEL, 32'hFF);
    rdchk("map last", ppfm_pkg::OFS_MAP_BASE + 8'h1C, 32'd30);
    periph_oe <= 31'h0;
    wr(ppfm_pkg::OFS_REMAP_DIR, 32'hFF);
    wr(ppfm_pkg::OFS_MAP_BASE + 8'h18, 32'd31);
    repeat (3) @(posedge hclk);
    check("dir oe", remap_pad.oe, 8'hBD);
    check("dir out", remap_pad.out & 8'hBD, 8'hBD);
    check("parked", remap_pad.in_en, 8'hBF);
    rdchk("map six", ppfm_pkg::OFS_MAP_BASE + 8'h18, 32'd31);
  endtask

  task automatic t_analog;
    logic [3:0] ch;
    wr(ppfm_pkg::OFS_FIFTH_SEL, 32'h03);
    for (int k = 0; k < 6; k++) begin
      ch = (k < 2) ? 4'h8 : (k < 4) ? 4'h9 : 4'h3;
      wr(ppfm_pkg::OFS_CTRL, {ch, 3'h0, k[0]});
      repeat (2) @(posedge hclk);
      check("analog", analog, {ch == 4'h8, ch == 4'h9, !k[0], k[0], !k[0], k[0]});
      check("ref pads", {fifth_pad.out[1:0], fifth_pad.oe[1:0], fifth_pad.in_en[1:0]}, 6'h00);
      rdchk("ctrl", ppfm_pkg::OFS_CTRL, {ch, 3'h0, k[0]});
    end
  endtask

  task automatic t_osc;
    logic h;
    logic l;
    logic [7:0] eo;
    for (int k = 0; k < 5; k++) begin
      h = k[0];
      l = k[1];
      wr(ppfm_pkg::OFS_CTRL, {5'h0, l, h, 1'b0});
      wr(ppfm_pkg::OFS_FIFTH_SEL, (k < 4) ? 32'h14 : 32'h28);
      repeat (2) @(posedge hclk);
      if (k < 4) begin
        eo = {1'b1, h, !h, h & fifth_ext[ppfm_pkg::PIN_HF_IN], 1'b1, l, !l, l & fifth_ext[ppfm_pkg::PIN_LF_IN]};
        check("osc", osc, eo);
        rdchk("status", ppfm_pkg::OFS_STATUS, {24'h0, eo});
        check("osc oe", fifth_pad.oe[5:2], {l, 1'b0, h, 1'b0});
        check("osc in_en", fifth_pad.in_en[5:2], {l, l, h, h});
      end else begin
        check("own sel", fifth_pad.oe[5:2], 4'hA);
        check("osc off", osc, 8'h00);
      end
    end
  endtask

  initial begin
    t_reset();
    t_gpio();
    t_mapped();
    t_analog();
    t_osc();
    t_reset();
    test_done();
  end
endmodule
